// ===== rtl/quad_switch_fault_diagnostics.sv
// top of the quad switch fault detection, reporting and sense multiplexing
// Notes on behaviour
// R1 - diag off, input high: keep protection, release sense and fault outputs
// R2 - diag off, input low: no diagnostics, no protection, outputs released
// R3 - select pins 00..11 route sense to channels one to four
// R4 - no fault: fault pins released; sense zero when off, linear when on
// R5 - current limit on an on channel pulls status, global fault, sense high
// R6 - off channel with open load reports a fault, clears automatically
// R7 - on-state open load is not reported; host judges the sense level
// R8 - short to battery and reverse polarity use the open-load path
// R9 - each channel has an active-low open-drain status output
// R10 - one active-low open-drain global fault for any channel
// R11 - faulting selected channel drives sense to the fixed fault level
// R12 - thermal shutdown turns the channel off and reports a fault
// R13 - thermal faults tracked per channel from each own sensor
// R14 - mode low: output retries when cool, current limit reduced
// R15 - auto-retry fault clears on reset threshold or input toggle
// R16 - mode high: output latched off until the input toggles
// R17 - mode falling high to low switches latch to auto-retry
// R18 - thermal swing turns output off, reports, recovers automatically
// R19 - undervoltage shuts all channels down, resume on recovery
// R20 - standby only after input low longer than the deglitch time
// R21 - inputs synchronised; toggle seen as low then high
`timescale 1ns/10ps
module quad_switch_fault_diagnostics #(
   parameter int NUM_CH         = qsw_pkg::NUM_CHANNELS,
   parameter int STANDBY_CYCLES = qsw_pkg::STANDBY_DEG_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [NUM_CH-1:0] channel_input,
   input  wire logic              diagnostic_enable,
   input  wire logic              sense_select_high,
   input  wire logic              sense_select_low,
   input  wire logic              thermal_mode_select,
   input  wire logic [NUM_CH-1:0] curLimitFlag,
   input  wire logic [NUM_CH-1:0] openLoadFlag,
   input  wire logic [NUM_CH-1:0] thermalShutFlag,
   input  wire logic [NUM_CH-1:0] thermalResetFlag,
   input  wire logic [NUM_CH-1:0] thermalSwingFlag,
   input  wire logic              underVoltage,
   output logic      [NUM_CH-1:0] channel_output,
   output logic      [NUM_CH-1:0] reducedLimit,
   output logic      [NUM_CH-1:0] protectEnable,
   output logic      [NUM_CH-1:0] standby,
   output logic      [NUM_CH-1:0] channel_status_n_o,
   output logic      [NUM_CH-1:0] channel_status_n_oe,
   output logic                   globalFault_n_o,
   output logic                   globalFault_n_oe,
   output logic      [1:0]        senseLevel,
   output logic                   senseEnable
);
   // elaboration-time refusal: the two select pins address exactly four channels
   if (NUM_CH != 4) begin : g_bad_count
      $error("sense select serves exactly four channels");
   end

   logic [NUM_CH-1:0] inSync1_reg;
   logic [NUM_CH-1:0] inSync2_reg;
   logic [NUM_CH-1:0] inPrev_reg;
   logic [NUM_CH-1:0] chOn;
   logic [NUM_CH-1:0] chFault;
   logic [NUM_CH-1:0] chReduced;
   logic [NUM_CH-1:0] chProtect;
   logic [NUM_CH-1:0] chStandby;
   logic [1:0]        select;
   logic              selFault;
   logic              selInput;
   qsw_pkg::sense_level_t senseNext;

   // two-stage input synchroniser and edge history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inSync1_reg <= '0;
         inSync2_reg <= '0;
         inPrev_reg  <= '0;
      end else begin
         inSync1_reg <= channel_input; // R21
         inSync2_reg <= inSync1_reg;
         inPrev_reg  <= inSync2_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         channel_if cif ();
         assign cif.inputSync        = inSync2_reg[g];
         assign cif.inputRise        = inSync2_reg[g] && !inPrev_reg[g]; // R21
         assign cif.diagEnable       = diagnostic_enable;
         assign cif.thermalLatchMode = thermal_mode_select;
         assign cif.curLimitFlag     = curLimitFlag[g];
         assign cif.openLoadFlag     = openLoadFlag[g];
         assign cif.thermalShutFlag  = thermalShutFlag[g];
         assign cif.thermalResetFlag = thermalResetFlag[g];
         assign cif.thermalSwingFlag = thermalSwingFlag[g];
         assign cif.underVoltage     = underVoltage; // R19
         assign chOn[g]      = cif.outputOn;
         assign chFault[g]   = cif.fault;
         assign chReduced[g] = cif.reducedLimit;
         assign chProtect[g] = cif.protectEnable;
         assign chStandby[g] = cif.standby;
         switch_channel #(
            .STANDBY_CYCLES (STANDBY_CYCLES)
         ) u_ch (
            .clk   (clk),
            .rst_n (rst_n),
            .ch    (cif)
         );
      end
   endgenerate

   assign select   = {sense_select_high, sense_select_low}; // R3
   assign selFault = chFault[select];
   assign selInput = inSync2_reg[select];

   always_comb begin
      if (selFault) begin
         senseNext = qsw_pkg::SENSE_FAULT; // R11 R5
      end else if (selInput) begin
         senseNext = qsw_pkg::SENSE_LINEAR; // R4
      end else begin
         senseNext = qsw_pkg::SENSE_ZERO;
      end
   end

   // output registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_output <= '0;
         reducedLimit   <= '0;
         protectEnable  <= '0;
         standby        <= '1;
      end else begin
         channel_output <= chOn;
         reducedLimit   <= chReduced;
         protectEnable  <= chProtect; // R1 R2
         standby        <= chStandby;
      end
   end

   // open-drain reporting: drive low only on fault, released otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_status_n_o  <= '0;
         channel_status_n_oe <= '0;
         globalFault_n_o     <= 1'b0;
         globalFault_n_oe    <= 1'b0;
      end else begin
         channel_status_n_o  <= '0;
         channel_status_n_oe <= chFault; // R9
         globalFault_n_o     <= 1'b0;
         globalFault_n_oe    <= |chFault; // R10
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         senseLevel  <= qsw_pkg::SENSE_RESET;
         senseEnable <= 1'b0;
      end else begin
         senseLevel  <= diagnostic_enable ? senseNext : qsw_pkg::SENSE_RESET;
         senseEnable <= diagnostic_enable; // R1 R2
      end
   end
endmodule : quad_switch_fault_diagnostics

// ===== rtl/qsw_pkg.sv
// shared constants and types for the quad switch fault diagnostics
package qsw_pkg;
   localparam int          NUM_CHANNELS   = 4;
   localparam int          CLK_FREQ_MHZ   = 125;
   // standby deglitch time in microseconds, a plain default
   localparam int          STANDBY_DEG_US = 100;
   localparam int          STANDBY_DEG_CYCLES = STANDBY_DEG_US * CLK_FREQ_MHZ;
   localparam logic [1:0]  SENSE_SEL_RESET = 2'h0;
   localparam logic [1:0]  SENSE_RESET     = 2'h0;

   // sense output meaning
   typedef enum logic [1:0] {
      SENSE_ZERO   = 2'h0,
      SENSE_LINEAR = 2'h1,
      SENSE_FAULT  = 2'h2
   } sense_level_t;

   // thermal shutdown handling per channel
   typedef enum logic [2:0] {
      TH_IDLE    = 3'h1,
      TH_RETRY   = 3'h2,
      TH_LATCHED = 3'h4
   } thermal_state_t;
endpackage : qsw_pkg

// ===== rtl/channel_if.sv
// per-channel signals passed between the top and the channel logic
`timescale 1ns/10ps
interface channel_if;
   logic inputSync;
   logic inputRise;
   logic diagEnable;
   logic thermalLatchMode;
   logic curLimitFlag;
   logic openLoadFlag;
   logic thermalShutFlag;
   logic thermalResetFlag;
   logic thermalSwingFlag;
   logic underVoltage;
   logic outputOn;
   logic reducedLimit;
   logic protectEnable;
   logic fault;
   logic standby;

   modport top (
      output inputSync, inputRise, diagEnable, thermalLatchMode, curLimitFlag,
             openLoadFlag, thermalShutFlag, thermalResetFlag, thermalSwingFlag,
             underVoltage,
      input  outputOn, reducedLimit, protectEnable, fault, standby
   );
   modport chan (
      input  inputSync, inputRise, diagEnable, thermalLatchMode, curLimitFlag,
             openLoadFlag, thermalShutFlag, thermalResetFlag, thermalSwingFlag,
             underVoltage,
      output outputOn, reducedLimit, protectEnable, fault, standby
   );
endinterface : channel_if

// ===== rtl/switch_channel.sv
// fault tracking and output gating for one channel
`timescale 1ns/10ps
module switch_channel #(
   parameter int STANDBY_CYCLES = qsw_pkg::STANDBY_DEG_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_n,
   channel_if.chan   ch
);
   // elaboration-time refusal of a count the low-time counter cannot serve
   if (STANDBY_CYCLES < 1) begin : g_bad_standby
      $error("standby count must be positive");
   end

   localparam int CW = $clog2(STANDBY_CYCLES + 1);

   qsw_pkg::thermal_state_t thState_reg;
   logic [CW-1:0]           lowCount_reg;
   logic                    standby_reg;
   logic                    tsdFault;
   logic                    reduced_reg;

   // thermal state per channel from its own sensor flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thState_reg <= qsw_pkg::TH_IDLE;
      end else begin
         case (thState_reg)
            qsw_pkg::TH_IDLE: begin
               if (ch.inputSync && ch.thermalShutFlag) begin // R12 R13
                  thState_reg <= ch.thermalLatchMode ? qsw_pkg::TH_LATCHED
                                                     : qsw_pkg::TH_RETRY;
               end
            end
            qsw_pkg::TH_RETRY: begin
               if (ch.thermalLatchMode && ch.thermalShutFlag) begin
                  thState_reg <= qsw_pkg::TH_LATCHED;
               end else if (ch.thermalResetFlag || ch.inputRise) begin // R15
                  thState_reg <= qsw_pkg::TH_IDLE;
               end
            end
            qsw_pkg::TH_LATCHED: begin
               if (ch.inputRise) begin // R16 R21
                  thState_reg <= qsw_pkg::TH_IDLE;
               end else if (!ch.thermalLatchMode) begin // R17
                  thState_reg <= qsw_pkg::TH_RETRY;
               end
            end
            default: thState_reg <= qsw_pkg::TH_IDLE;
         endcase
      end
   end

   // reduced current limit after an auto-retry recovery
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reduced_reg <= 1'b0;
      end else if (thState_reg == qsw_pkg::TH_IDLE) begin
         reduced_reg <= 1'b0;
      end else if (thState_reg == qsw_pkg::TH_RETRY && !ch.thermalShutFlag) begin
         reduced_reg <= 1'b1; // R14
      end
   end

   // standby entry after the input stays low past the deglitch time, with diagnostics off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCount_reg <= '0;
         standby_reg  <= 1'b1;
      end else if (ch.inputSync) begin
         lowCount_reg <= '0;
         standby_reg  <= 1'b0;
      end else if (lowCount_reg < CW'(STANDBY_CYCLES)) begin
         lowCount_reg <= lowCount_reg + CW'(1);
      end else begin
         standby_reg <= !ch.diagEnable; // R20
      end
   end

   logic retryOff;
   logic thermalOff;
   logic offFault;
   logic onFault;
   assign retryOff   = thState_reg == qsw_pkg::TH_RETRY && ch.thermalShutFlag; // R14
   assign thermalOff = thState_reg == qsw_pkg::TH_LATCHED || retryOff; // R16
   assign tsdFault   = thState_reg != qsw_pkg::TH_IDLE;

   // protection runs with the input high; off-state low input has none
   assign ch.protectEnable = ch.inputSync; // R1 R2
   assign ch.outputOn = ch.inputSync && !thermalOff && !ch.thermalSwingFlag // R18
                        && !ch.underVoltage; // R19
   assign ch.reducedLimit = reduced_reg;
   assign ch.standby = standby_reg;
   // open load only counts while off; an on-state open load is left to the host
   assign offFault = !ch.inputSync && ch.openLoadFlag; // R6 R7 R8
   assign onFault  = ch.inputSync && (ch.curLimitFlag || ch.thermalSwingFlag); // R5 R18
   assign ch.fault = ch.diagEnable && (offFault || onFault || tsdFault); // R12
endmodule : switch_channel

// ===== verif/quad_switch_chk.sv
// port assertions for the quad switch fault diagnostics top
`timescale 1ns/10ps
module quad_switch_chk #(
   parameter int NUM_CH         = qsw_pkg::NUM_CHANNELS,
   parameter int STANDBY_CYCLES = qsw_pkg::STANDBY_DEG_CYCLES
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [NUM_CH-1:0] channel_input,
   input wire logic              diagnostic_enable,
   input wire logic              sense_select_high,
   input wire logic              sense_select_low,
   input wire logic [NUM_CH-1:0] curLimitFlag,
   input wire logic [NUM_CH-1:0] openLoadFlag,
   input wire logic [NUM_CH-1:0] thermalSwingFlag,
   input wire logic              underVoltage,
   input wire logic [NUM_CH-1:0] channel_output,
   input wire logic [NUM_CH-1:0] standby,
   input wire logic [NUM_CH-1:0] channel_status_n_o,
   input wire logic [NUM_CH-1:0] channel_status_n_oe,
   input wire logic              globalFault_n_o,
   input wire logic              globalFault_n_oe,
   input wire logic [1:0]        senseLevel,
   input wire logic              senseEnable
);
   logic [15:0] lowCnt;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // raw low time of channel 1, longer than the synced view
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) lowCnt <= 16'h0;
      else if (channel_input[0]) lowCnt <= 16'h0;
      else if (lowCnt != 16'hffff) lowCnt <= lowCnt + 16'h1;
   end

   drive_low_a: assert property (channel_status_n_o == '0 && !globalFault_n_o)
      else $error("open drain data not low");
   diag_off_a: assert property (!diagnostic_enable |=> channel_status_n_oe == '0)
      else $error("status pulled with diag off");
   sense_off_a: assert property (!diagnostic_enable |=> !senseEnable && senseLevel == 2'h0)
      else $error("sense driven with diag off");
   global_any_a: assert property (globalFault_n_oe == |channel_status_n_oe)
      else $error("global fault mismatch");
   cur_limit_a: assert property (
      channel_input[0] [*4] ##0 (diagnostic_enable && curLimitFlag[0])
      |=> channel_status_n_oe[0])
      else $error("current limit not reported");
   open_load_a: assert property (
      !channel_input[1] [*4] ##0 (diagnostic_enable && openLoadFlag[1])
      |=> channel_status_n_oe[1])
      else $error("open load not reported");
   sense_fault_a: assert property (
      channel_input[0] [*4] ##0 (diagnostic_enable && curLimitFlag[0]
      && !sense_select_high && !sense_select_low)
      |=> senseLevel == 2'h2)
      else $error("sense not at fault level");
   uv_off_a: assert property (underVoltage |=> channel_output == '0)
      else $error("output on in undervoltage");
   swing_off_a: assert property (
      thermalSwingFlag != '0 |=> (channel_output & $past(thermalSwingFlag)) == '0)
      else $error("output on in thermal swing");
   standby_wait_a: assert property ($rose(standby[0]) |-> lowCnt >= STANDBY_CYCLES)
      else $error("standby entered early");

   cover property (globalFault_n_oe && senseLevel == 2'h2);
   cover property (underVoltage ##1 channel_output == '0);
   cover property ($rose(standby[0]));
endmodule : quad_switch_chk

bind quad_switch_fault_diagnostics quad_switch_chk #(
   .NUM_CH(NUM_CH), .STANDBY_CYCLES(STANDBY_CYCLES)) portChk (
   .clk, .rst_n, .channel_input, .diagnostic_enable, .sense_select_high,
   .sense_select_low, .curLimitFlag, .openLoadFlag, .thermalSwingFlag, .underVoltage,
   .channel_output, .standby, .channel_status_n_o, .channel_status_n_oe,
   .globalFault_n_o, .globalFault_n_oe, .senseLevel, .senseEnable);

// ===== verif/host_mcu_model.sv
// host side pull-ups that resolve the open-drain fault lines
`timescale 1ns/10ps
module host_mcu_model (
   input  wire logic [3:0] statusOe,
   input  wire logic [3:0] statusO,
   input  wire logic       faultOe,
   input  wire logic       faultO,
   output logic      [3:0] statusLine,
   output logic            faultLine
);
   // a released line floats up to the pull-up level
   assign statusLine = (statusOe & statusO) | ~statusOe;
   assign faultLine  = faultOe ? faultO : 1'b1;
endmodule : host_mcu_model

// ===== verif/quad_switch_fault_diagnostics_test.sv
// self-checking bench for the quad switch fault diagnostics
`timescale 1ns/10ps
module quad_switch_fault_diagnostics_test;
   logic       clk, rst_n, diag, selH, selL, mode, uv, gfO, gfOe, gfLine, senEn;
   logic [3:0] chIn, cl, ol, ts, tr, sw, chOut, redLim, protEn, stby, stO, stOe, stLine;
   logic [1:0] senLvl;
   int         num_errors;
   int         comparisons;
   int         cycles;

   quad_switch_fault_diagnostics #(.STANDBY_CYCLES(8)) dut (
      .clk(clk), .rst_n(rst_n), .channel_input(chIn), .diagnostic_enable(diag),
      .sense_select_high(selH), .sense_select_low(selL), .thermal_mode_select(mode),
      .curLimitFlag(cl), .openLoadFlag(ol), .thermalShutFlag(ts), .thermalResetFlag(tr),
      .thermalSwingFlag(sw), .underVoltage(uv), .channel_output(chOut),
      .reducedLimit(redLim), .protectEnable(protEn), .standby(stby),
      .channel_status_n_o(stO), .channel_status_n_oe(stOe), .globalFault_n_o(gfO),
      .globalFault_n_oe(gfOe), .senseLevel(senLvl), .senseEnable(senEn));
   host_mcu_model host (.statusOe(stOe), .statusO(stO), .faultOe(gfOe), .faultO(gfO),
      .statusLine(stLine), .faultLine(gfLine));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic settle();
      repeat (6) @(posedge clk);
      #2;
   endtask : settle

   task automatic drive(input logic [3:0] i, c, o, t, r, s);
      @(posedge clk);
      chIn <= i;
      cl <= c;
      ol <= o;
      ts <= t;
      tr <= r;
      sw <= s;
      settle();
   endtask : drive

   task automatic ctl(input logic d, input logic [1:0] sel, input logic m, input logic u);
      @(posedge clk);
      diag <= d;
      {selH, selL} <= sel;
      mode <= m;
      uv <= u;
      settle();
   endtask : ctl

   initial begin
      rst_n = 1'b0;
      {chIn, cl, ol, ts, tr, sw} = '0;
      {diag, selH, selL, mode, uv} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      drive(4'hf, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("status oe", 4'h0, stOe);
      chk("sense", 4'h0, {1'b0, senEn, senLvl});
      chk("protect", 4'hf, protEn);
      chk("standby", 4'h0, stby);
      ctl(1'b1, 2'h0, 1'b0, 1'b0);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("status lines", 4'hf, stLine);
      chk("fault line", 4'h1, {3'h0, gfLine});
      chk("sense", 4'h5, {1'b0, senEn, senLvl});
      chk("output", 4'hf, chOut);
      drive(4'he, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("sense", 4'h4, {1'b0, senEn, senLvl});
      drive(4'hf, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0);
      for (int s = 0; s < 4; s++) begin
         ctl(1'b1, s[1:0], 1'b0, 1'b0);
         chk("sense", (s == 2) ? 4'h6 : 4'h5, {1'b0, senEn, senLvl});
      end
      chk("status lines", 4'hb, stLine);
      chk("fault line", 4'h0, {3'h0, gfLine});
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("status lines", 4'hf, stLine);
      drive(4'h5, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0);
      chk("status oe", 4'ha, stOe);
      ctl(1'b1, 2'h1, 1'b0, 1'b0);
      chk("sense", 4'h6, {1'b0, senEn, senLvl});
      ctl(1'b1, 2'h0, 1'b0, 1'b0);
      chk("sense", 4'h5, {1'b0, senEn, senLvl});
      drive(4'hf, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
      chk("output", 4'he, chOut);
      chk("status oe", 4'h1, stOe);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("output", 4'hf, chOut);
      chk("reduced", 4'h1, redLim);
      chk("status oe", 4'h1, stOe);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
      chk("status oe", 4'h0, stOe);
      chk("reduced", 4'h0, redLim);
      ctl(1'b1, 2'h0, 1'b1, 1'b0);
      drive(4'hf, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("output", 4'he, chOut);
      ctl(1'b1, 2'h0, 1'b0, 1'b0);
      chk("output", 4'hf, chOut);
      chk("status oe", 4'h1, stOe);
      ctl(1'b1, 2'h0, 1'b1, 1'b0);
      drive(4'hf, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
      drive(4'he, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("status oe", 4'h1, stOe);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("status oe", 4'h0, stOe);
      chk("output", 4'hf, chOut);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2);
      chk("output", 4'hd, chOut);
      chk("status oe", 4'h2, stOe);
      drive(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
      chk("output", 4'hf, chOut);
      ctl(1'b1, 2'h0, 1'b0, 1'b1);
      chk("output", 4'h0, chOut);
      ctl(1'b1, 2'h0, 1'b0, 1'b0);
      chk("output", 4'hf, chOut);
      ctl(1'b0, 2'h0, 1'b0, 1'b0);
      drive(4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0);
      settle();
      chk("standby", 4'hf, stby);
      chk("status oe", 4'h0, stOe);
      chk("protect", 4'h0, protEn);
      chk("sense", 4'h0, {1'b0, senEn, senLvl});
      // let the standby rise be seen by the checker before the run ends
      settle();
      chk("standby", 4'hf, stby);
      end_of_test();
   end
endmodule : quad_switch_fault_diagnostics_test
